// ==== hdl/sev_pkg.sv ====
// Constants, offsets and code tables for the system event vector block
// Overview of operation
// - Three read-only vectors return the code of the highest-priority pending source, or 00h when idle.
// - Reset codes: brownout 02h, reset pin 04h, soft brownout 06h, wake 08h, security 0Ah, supply-high 0Eh.
// - Reset codes: soft power-on 14h, watchdog expiry 16h, watchdog key 18h, all three power-up-clear class.
// - Reset codes: memory key 1Ah, uncorrectable memory 1Ch, peripheral fetch 1Eh, power key 20h, lock loss 24h.
// - System NMI codes: supervisor low-power reset entry 02h highest, uncorrectable memory error 04h.
// - System NMI codes: vacant access 12h, mailbox in 14h, mailbox out 16h, correctable memory 18h lowest.
// - User NMI codes: NMI pin or supply-high supervisor 02h highest, oscillator fault 04h.
// - A mailbox exchanges data words with the debugger; its in and out events are system NMI sources.
package sev_pkg;
    localparam int unsigned VEC_W    = 16;
    localparam int unsigned CODE_W   = 8;
    // Offsets are word indices; the byte address is four times each
    localparam int unsigned UNMI_IDX = 32'h0000015a;
    localparam int unsigned SNMI_IDX = 32'h0000015c;
    localparam int unsigned RST_IDX  = 32'h0000015e;
    localparam logic [11:0] UNMI_ADDR   = 12'(4 * UNMI_IDX);
    localparam logic [11:0] SNMI_ADDR   = 12'(4 * SNMI_IDX);
    localparam logic [11:0] RST_ADDR    = 12'(4 * RST_IDX);
    localparam logic [11:0] STATUS_ADDR = 12'h580;
    localparam logic [11:0] MASK_ADDR   = 12'h584;
    localparam logic [11:0] MBIN_ADDR   = 12'h588;
    localparam logic [11:0] MBOUT_ADDR  = 12'h58c;
    // Source slot counts; slot 0 is highest priority
    localparam int unsigned RST_N  = 14;
    localparam int unsigned SNMI_N = 6;
    localparam int unsigned UNMI_N = 2;
    // System NMI slot positions
    localparam int unsigned SN_SVS_LP  = 0;
    localparam int unsigned SN_NVM_UNC = 1;
    localparam int unsigned SN_VACANT  = 2;
    localparam int unsigned SN_MB_IN   = 3;
    localparam int unsigned SN_MB_OUT  = 4;
    localparam int unsigned SN_NVM_COR = 5;
    // User NMI slot positions
    localparam int unsigned UN_NMI = 0;
    localparam int unsigned UN_OSC = 1;
    // Code tables, indexed by slot; reserved codes simply have no slot
    localparam logic [7:0] RST_CODES [RST_N] = '{
        8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0e, 8'h14,
        8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20, 8'h24};
    localparam logic [7:0] SNMI_CODES [SNMI_N] = '{
        8'h02, 8'h04, 8'h12, 8'h14, 8'h16, 8'h18};
    localparam logic [7:0] UNMI_CODES [UNMI_N] = '{8'h02, 8'h04};
    // Interrupt status bit positions
    localparam int unsigned IRQ_RST  = 0;
    localparam int unsigned IRQ_SNMI = 1;
    localparam int unsigned IRQ_UNMI = 2;
    localparam int unsigned IRQ_W    = 3;
    // Values after reset
    localparam logic [2:0]  MASK_RST = 3'h0;
    localparam logic [15:0] MBOX_RST = 16'h0000;
endpackage

// ==== hdl/lowest_set_picker.sv ====
// Picks the lowest set bit of a pending vector as a one-hot grant
`timescale 1ns/1ps
module lowest_set_picker #(
    parameter int unsigned N = 4
) (
    input  wire logic [N-1:0] pending,
    output wire logic [N-1:0] grant,
    output wire logic         any
);
    // Two's complement isolates the lowest set bit without a priority chain
    assign grant = pending & (~pending + {{(N-1){1'b0}}, 1'b1});
    assign any   = |pending;
endmodule

// ==== hdl/system_event_vectors.sv ====
// Prioritised reset, system NMI and user NMI vector registers with mailbox over APB
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module system_event_vectors (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [11:0]              paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [sev_pkg::RST_N-1:0] reset_cause_in,
    input  wire logic                     supervisor_lp_entry,
    input  wire logic                     nvm_uncorrectable_error,
    input  wire logic                     vacant_access_flag,
    input  wire logic                     nvm_correctable_error,
    input  wire logic                     nmi_pin,
    input  wire logic                     supply_high_supervisor_flag,
    input  wire logic                     osc_fault_flag,
    input  wire logic                     dbg_in_valid,
    input  wire logic [15:0]              dbg_in_data,
    input  wire logic                     dbg_out_take,
    output logic      [15:0]              dbg_out_data,
    output logic                          dbg_out_full,
    output logic                          irq
);
    import sev_pkg::*;

    // Pending source flags per vector
    logic [RST_N-1:0]  rst_flag_reg;
    logic [SNMI_N-1:0] snmi_flag_reg;
    logic [UNMI_N-1:0] unmi_flag_reg;
    logic [RST_N-1:0]  rst_take_reg;
    logic [SNMI_N-1:0] snmi_take_reg;
    logic [UNMI_N-1:0] unmi_take_reg;
    logic [IRQ_W-1:0]  stat_reg;
    logic [IRQ_W-1:0]  stat_take_reg;
    logic [IRQ_W-1:0]  mask_reg;
    logic [15:0]       mbox_in_reg;
    logic [15:0]       mbox_out_reg;
    logic              mbox_full_reg;
    logic              nmi_s1_reg;
    logic              nmi_s2_reg;
    logic              nmi_s3_reg;
    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              irq_reg;

    // Next values
    logic [RST_N-1:0]  rst_flag_next;
    logic [SNMI_N-1:0] snmi_flag_next;
    logic [UNMI_N-1:0] unmi_flag_next;
    logic [IRQ_W-1:0]  stat_next;
    logic [15:0]       mbox_out_next;
    logic              mbox_full_next;

    // Priority grants
    logic [RST_N-1:0]  rst_grant;
    logic [SNMI_N-1:0] snmi_grant;
    logic [UNMI_N-1:0] unmi_grant;
    logic              rst_any;
    logic              snmi_any;
    logic              unmi_any;

    // Code chains, one stage per slot
    logic [CODE_W-1:0] rst_chain  [RST_N+1];
    logic [CODE_W-1:0] snmi_chain [SNMI_N+1];
    logic [CODE_W-1:0] unmi_chain [UNMI_N+1];
    logic [CODE_W-1:0] rst_code;
    logic [CODE_W-1:0] snmi_code;
    logic [CODE_W-1:0] unmi_code;

    // Bus decode
    logic        setup;
    logic        done;
    logic        rd_done;
    logic        wr_done;
    logic        sel_unmi;
    logic        sel_snmi;
    logic        sel_rst;
    logic        sel_stat;
    logic        sel_mask;
    logic        sel_mbin;
    logic        sel_mbout;
    logic        addr_hit;
    logic        rd_setup;
    logic [31:0] rd_mux;
    logic [15:0] wr_lanes;

    // Event sources
    logic              nmi_rise;
    logic [RST_N-1:0]  rst_set;
    logic [SNMI_N-1:0] snmi_set;
    logic [UNMI_N-1:0] unmi_set;
    logic [IRQ_W-1:0]  stat_set;
    logic              mbox_emptied;

    // APB phases; the answer comes in the first access cycle
    assign setup   = psel & ~penable;
    assign done    = psel & penable & pready_reg;
    assign rd_done = done & ~pwrite;
    assign wr_done = done & pwrite;

    // Address decode
    assign sel_unmi  = (paddr == UNMI_ADDR);
    assign sel_snmi  = (paddr == SNMI_ADDR);
    assign sel_rst   = (paddr == RST_ADDR);
    assign sel_stat  = (paddr == STATUS_ADDR);
    assign sel_mask  = (paddr == MASK_ADDR);
    assign sel_mbin  = (paddr == MBIN_ADDR);
    assign sel_mbout = (paddr == MBOUT_ADDR);
    assign addr_hit  = sel_unmi | sel_snmi | sel_rst | sel_stat | sel_mask | sel_mbin | sel_mbout;
    assign rd_setup  = setup & ~pwrite;

    // Priority pickers, slot 0 wins
    lowest_set_picker #(.N(RST_N)) u_rst_pick (
        .pending (rst_flag_reg),
        .grant   (rst_grant),
        .any     (rst_any)
    );
    lowest_set_picker #(.N(SNMI_N)) u_snmi_pick (
        .pending (snmi_flag_reg),
        .grant   (snmi_grant),
        .any     (snmi_any)
    );
    lowest_set_picker #(.N(UNMI_N)) u_unmi_pick (
        .pending (unmi_flag_reg),
        .grant   (unmi_grant),
        .any     (unmi_any)
    );

    // Map one-hot grants to codes; only table codes can appear, never a reserved one
    assign rst_chain[0]  = '0;
    assign snmi_chain[0] = '0;
    assign unmi_chain[0] = '0;
    for (genvar i = 0; i < RST_N; i++) begin : g_rst_code
        assign rst_chain[i+1] = rst_chain[i] |
                                (rst_grant[i] ? RST_CODES[i] : 8'h00);
    end
    for (genvar i = 0; i < SNMI_N; i++) begin : g_snmi_code
        assign snmi_chain[i+1] = snmi_chain[i] | (snmi_grant[i] ? SNMI_CODES[i] : 8'h00);
    end
    for (genvar i = 0; i < UNMI_N; i++) begin : g_unmi_code
        assign unmi_chain[i+1] = unmi_chain[i] | (unmi_grant[i] ? UNMI_CODES[i] : 8'h00);
    end
    // Zero when nothing is pending falls out of the empty grant
    assign rst_code  = rst_chain[RST_N];
    assign snmi_code = snmi_chain[SNMI_N];
    assign unmi_code = unmi_chain[UNMI_N];

    // Read data selection; unused upper bits read as zero
    assign rd_mux = sel_unmi  ? {24'h000000, unmi_code} :
                    sel_snmi  ? {24'h000000, snmi_code} :
                    sel_rst   ? {24'h000000, rst_code} :
                    sel_stat  ? {29'h00000000, stat_reg} :
                    sel_mask  ? {29'h00000000, mask_reg} :
                    sel_mbin  ? {16'h0000, mbox_in_reg} :
                    sel_mbout ? {16'h0000, mbox_out_reg} :
                    32'h00000000;

    // Byte lanes for the 16-bit mailbox register
    assign wr_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // NMI pin edge; the first sync stage feeds only the second
    assign nmi_rise = nmi_s2_reg & ~nmi_s3_reg;

    // Mailbox out emptied when the debugger takes a full word
    assign mbox_emptied = dbg_out_take & mbox_full_reg;

    // Event sets per vector
    assign rst_set = reset_cause_in;
    assign snmi_set[SN_SVS_LP]  = supervisor_lp_entry;
    assign snmi_set[SN_NVM_UNC] = nvm_uncorrectable_error;
    assign snmi_set[SN_VACANT]  = vacant_access_flag;
    assign snmi_set[SN_MB_IN]   = dbg_in_valid;
    assign snmi_set[SN_MB_OUT]  = mbox_emptied;
    assign snmi_set[SN_NVM_COR] = nvm_correctable_error;
    assign unmi_set[UN_NMI] = nmi_rise | supply_high_supervisor_flag;
    assign unmi_set[UN_OSC] = osc_fault_flag;

    // Read clears the reported flag; a new set in the same cycle wins
    assign rst_flag_next  = (rst_flag_reg & ~(rd_done ? rst_take_reg : '0)) | rst_set;
    assign snmi_flag_next = (snmi_flag_reg & ~(rd_done ? snmi_take_reg : '0)) | snmi_set;
    assign unmi_flag_next = (unmi_flag_reg & ~(rd_done ? unmi_take_reg : '0)) | unmi_set;

    // Status fires only on a newly raised flag, so held levels do not refire
    assign stat_set[IRQ_RST]  = |(rst_set & ~rst_flag_reg);
    assign stat_set[IRQ_SNMI] = |(snmi_set & ~snmi_flag_reg);
    assign stat_set[IRQ_UNMI] = |(unmi_set & ~unmi_flag_reg);
    assign stat_next = (stat_reg & ~(rd_done ? stat_take_reg : '0)) | stat_set;

    // Mailbox out: software loads it, the debugger empties it
    assign mbox_out_next  = (wr_done && sel_mbout) ?
                            ((mbox_out_reg & ~wr_lanes) | (pwdata[15:0] & wr_lanes)) : mbox_out_reg;
    assign mbox_full_next = (wr_done && sel_mbout) ? 1'b1 :
                            (mbox_emptied ? 1'b0 : mbox_full_reg);

    // NMI pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_s1_reg <= 1'b0;
            nmi_s2_reg <= 1'b0;
            nmi_s3_reg <= 1'b0;
        end else begin
            nmi_s1_reg <= nmi_pin;
            nmi_s2_reg <= nmi_s1_reg;
            nmi_s3_reg <= nmi_s2_reg;
        end
    end

    // Pending flags and interrupt status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_flag_reg  <= '0;
            snmi_flag_reg <= '0;
            unmi_flag_reg <= '0;
            stat_reg      <= '0;
        end else begin
            rst_flag_reg  <= rst_flag_next;
            snmi_flag_reg <= snmi_flag_next;
            unmi_flag_reg <= unmi_flag_next;
            stat_reg      <= stat_next;
        end
    end

    // Capture what the read reports, so only that source is cleared later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_take_reg  <= '0;
            snmi_take_reg <= '0;
            unmi_take_reg <= '0;
            stat_take_reg <= '0;
        end else if (setup) begin
            rst_take_reg  <= (rd_setup && sel_rst) ? rst_grant : '0;
            snmi_take_reg <= (rd_setup && sel_snmi) ? snmi_grant : '0;
            unmi_take_reg <= (rd_setup && sel_unmi) ? unmi_grant : '0;
            stat_take_reg <= (rd_setup && sel_stat) ? stat_reg : '0;
        end
    end

    // Software-written mask and mailbox registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg      <= MASK_RST;
            mbox_out_reg  <= MBOX_RST;
            mbox_full_reg <= 1'b0;
        end else begin
            if (wr_done && sel_mask && pstrb[0]) begin
                mask_reg <= pwdata[IRQ_W-1:0];
            end
            mbox_out_reg  <= mbox_out_next;
            mbox_full_reg <= mbox_full_next;
        end
    end

    // Mailbox in: a later word from the debugger overwrites an unread one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mbox_in_reg <= MBOX_RST;
        end else if (dbg_in_valid) begin
            mbox_in_reg <= dbg_in_data;
        end
    end

    // APB answer is registered so outputs come from flops; one cycle of setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
            pready_reg  <= 1'b1;
            pslverr_reg <= ~addr_hit;
        end else if (done || !psel) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Level interrupt, one cycle behind the status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    // Outputs straight from flops
    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign dbg_out_data = mbox_out_reg;
    assign dbg_out_full = mbox_full_reg;
    assign irq          = irq_reg;

endmodule

// ==== tb/sev_chk.sv ====
// Assertion checker for the system event vector block
`timescale 1ns/1ps
module sev_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dbg_out_take,
    input wire logic [15:0] dbg_out_data,
    input wire logic        dbg_out_full
);
    import sev_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_mbout_write;
        psel && penable && pready && pwrite && paddr == MBOUT_ADDR && pstrb[1:0] == 2'b11;
    endsequence
    // Completed good read, and whether the address decodes
    wire logic rd_ok  = pready && !pslverr && !pwrite;
    wire logic mapped = paddr inside {UNMI_ADDR, SNMI_ADDR, RST_ADDR, STATUS_ADDR, MASK_ADDR, MBIN_ADDR, MBOUT_ADDR};
    wire logic mb_wr  = psel && penable && pwrite && paddr == MBOUT_ADDR;

    a_ready_one_wait: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside first access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    a_map_error: assert property (pready |-> pslverr == !mapped && (!pslverr || prdata == 32'h0))
        else $error("slave error does not match address map");
    a_rst_codes: assert property (rd_ok && paddr == RST_ADDR |->
        prdata inside {32'h0, 32'h2, 32'h4, 32'h6, 32'h8, 32'ha, 32'he, 32'h14, 32'h16, 32'h18, 32'h1a, 32'h1c,
        32'h1e, 32'h20, 32'h24})
        else $error("reset cause vector gave an unassigned code");
    a_snmi_codes: assert property (rd_ok && paddr == SNMI_ADDR |->
        prdata inside {32'h0, 32'h2, 32'h4, 32'h12, 32'h14, 32'h16, 32'h18})
        else $error("system vector gave an unassigned code");
    a_unmi_codes: assert property (rd_ok && paddr == UNMI_ADDR |->
        prdata inside {32'h0, 32'h2, 32'h4})
        else $error("user vector gave an unassigned code");
    a_mbout_load: assert property (s_mbout_write |=> dbg_out_full && dbg_out_data == $past(pwdata[15:0]))
        else $error("mailbox out word not loaded");
    a_take_empties: assert property (dbg_out_take && !mb_wr |=> !dbg_out_full)
        else $error("mailbox out still full after take");
endmodule

bind system_event_vectors sev_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .dbg_out_take, .dbg_out_data, .dbg_out_full);

// ==== tb/testbench.sv ====
// Self-checking bench for the system event vector block
`timescale 1ns/1ps
module testbench;
    import sev_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, dbg_out_full, irq;
    logic [13:0] reset_cause_in = 0;
    logic        supervisor_lp_entry = 0, nvm_uncorrectable_error = 0, vacant_access_flag = 0;
    logic        nvm_correctable_error = 0, nmi_pin = 0, supply_high_supervisor_flag = 0;
    logic        osc_fault_flag = 0, dbg_in_valid = 0, dbg_out_take = 0;
    logic [15:0] dbg_in_data = 0, dbg_out_data;
    int          fail_count = 0, check_count = 0;

    // 20 MHz clock
    initial begin
        forever #25 pclk = ~pclk;
    end

    system_event_vectors u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .reset_cause_in, .supervisor_lp_entry, .nvm_uncorrectable_error, .vacant_access_flag,
        .nvm_correctable_error, .nmi_pin, .supply_high_supervisor_flag, .osc_fault_flag, .dbg_in_valid,
        .dbg_in_data, .dbg_out_take, .dbg_out_data, .dbg_out_full, .irq);

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask

    // One transfer; the request stands until pready is sampled high, bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            end_sim();
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_val(rd, exp);
    endtask

    task automatic t_reset_vals();
        rd_chk(RST_ADDR, 32'h0);
        rd_chk(SNMI_ADDR, 32'h0);
        rd_chk(UNMI_ADDR, 32'h0);
        rd_chk(MASK_ADDR, 32'h0);
        chk_bit(irq, 1'b0);
    endtask

    // All causes at once; reads must walk them in code order, then idle
    task automatic t_rst_order();
        logic [7:0] codes [15] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0e, 8'h14, 8'h16, 8'h18,
                                   8'h1a, 8'h1c, 8'h1e, 8'h20, 8'h24, 8'h00};
        @(posedge pclk);
        reset_cause_in <= 14'h3fff;
        @(posedge pclk);
        reset_cause_in <= 14'h0;
        foreach (codes[i]) rd_chk(RST_ADDR, {24'h0, codes[i]});
    endtask

    // Empty take first: it must raise nothing
    task automatic t_snmi();
        logic [7:0] codes [7] = '{8'h02, 8'h04, 8'h12, 8'h14, 8'h16, 8'h18, 8'h00};
        @(posedge pclk);
        dbg_out_take <= 1'b1;
        @(posedge pclk);
        dbg_out_take <= 1'b0;
        repeat (2) @(negedge pclk);
        rd_chk(SNMI_ADDR, 32'h0);
        apb(1'b1, MBOUT_ADDR, 32'h0000a5c3);
        @(negedge pclk);
        chk_bit(dbg_out_full, 1'b1);
        chk_val({16'h0, dbg_out_data}, 32'ha5c3);
        @(posedge pclk);
        dbg_in_data <= 16'h3c5a;
        {supervisor_lp_entry, nvm_uncorrectable_error, vacant_access_flag, nvm_correctable_error,
            dbg_in_valid, dbg_out_take} <= 6'h3f;
        @(posedge pclk);
        {supervisor_lp_entry, nvm_uncorrectable_error, vacant_access_flag, nvm_correctable_error,
            dbg_in_valid, dbg_out_take} <= 6'h00;
        repeat (2) @(negedge pclk);
        chk_bit(dbg_out_full, 1'b0);
        rd_chk(MBIN_ADDR, 32'h3c5a);
        foreach (codes[i]) rd_chk(SNMI_ADDR, {24'h0, codes[i]});
    endtask

    // Pin edge needs the synchroniser delay, so wait before reading
    task automatic t_unmi();
        @(posedge pclk);
        {nmi_pin, osc_fault_flag} <= 2'b11;
        @(posedge pclk);
        osc_fault_flag <= 1'b0;
        repeat (4) @(negedge pclk);
        rd_chk(UNMI_ADDR, 32'h2);
        rd_chk(UNMI_ADDR, 32'h4);
        rd_chk(UNMI_ADDR, 32'h0);
        @(posedge pclk);
        {nmi_pin, supply_high_supervisor_flag} <= 2'b01;
        @(posedge pclk);
        supply_high_supervisor_flag <= 1'b0;
        repeat (2) @(negedge pclk);
        rd_chk(UNMI_ADDR, 32'h2);
        rd_chk(UNMI_ADDR, 32'h0);
    endtask

    // Interrupt masking, status clear, read-only write and an unmapped address
    task automatic t_irq_bus();
        rd_chk(STATUS_ADDR, 32'h7);
        @(posedge pclk);
        osc_fault_flag <= 1'b1;
        @(posedge pclk);
        osc_fault_flag <= 1'b0;
        repeat (4) @(negedge pclk);
        chk_bit(irq, 1'b0);
        apb(1'b1, MASK_ADDR, 32'h4);
        repeat (2) @(negedge pclk);
        chk_bit(irq, 1'b1);
        rd_chk(MASK_ADDR, 32'h4);
        rd_chk(STATUS_ADDR, 32'h4);
        repeat (2) @(negedge pclk);
        chk_bit(irq, 1'b0);
        rd_chk(UNMI_ADDR, 32'h4);
        apb(1'b1, RST_ADDR, 32'h0000ffff);
        chk_bit(err, 1'b0);
        rd_chk(RST_ADDR, 32'h0);
        apb(1'b0, 12'h5f0, 32'h0);
        chk_bit(err, 1'b1);
        chk_val(rd, 32'h0);
        // Low byte lane only: the upper mailbox byte must survive
        @(posedge pclk);
        pstrb <= 4'h1;
        apb(1'b1, MBOUT_ADDR, 32'h00001177);
        pstrb <= 4'hf;
        @(negedge pclk);
        chk_bit(dbg_out_full, 1'b1);
        chk_val({16'h0, dbg_out_data}, 32'ha577);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_rst_order();
        t_snmi();
        t_unmi();
        t_irq_bus();
        end_sim();
    end
endmodule
